/* wiper_ctl_defs.vh */
// How it works
// - Session opens on select falling, held low.
// - Direction settles before strobe falls.
// - Strobe stays low after last step.
// - Select rising first ends without storing.
// - Strobe high early then select: store.
// - Short select pulse, strobe high: store.
`ifndef WIPER_CTL_DEFS_VH
`define WIPER_CTL_DEFS_VH
// ----------------------------------------
// Timing figures in their own units.
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define CS_TO_INC_NS 50
`define DIR_SETUP_NS 100
`define INC_LOW_NS 50
`define INC_HIGH_NS 100
`define STROBE_TO_DESELECT_NS 500
`define DESELECT_NS 100
`define SELECT_PULSE_NS 100
`define STORAGE_US 10000
`define WIPER_LOAD_US 500
`define POWERUP_WAIT_US 2000
// ----------------------------------------
// Cycle counts, minimums rounded up.
// ----------------------------------------
`define CYC_NS(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_US(t) (((t) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POS_COUNT 32
`define POS_MAX 5'h1F
`endif

/* hold_timer.v */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Down counter that flags when a wait has run out.
// ----------------------------------------
module hold_timer #(
   parameter W = 24
) (
   // Clock and reset.
   input wire core_clk,
   input wire rstn,
   // Load and status.
   input wire load,
   input wire [W-1:0] count,
   output wire done
);
   reg [W-1:0] left; // Cycles still to wait.
   assign done = (left == {W{1'b0}});
   // Load wins; otherwise count down to zero and stay.
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         left <= {W{1'b0}};
      end else if (load) begin
         left <= count;
      end else if (!done) begin
         left <= left - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

/* wiper_host.v */
`timescale 1ns/10ps
`default_nettype none
`include "wiper_ctl_defs.vh"
// ----------------------------------------
// Host that drives the select, strobe and direction pins.
// ----------------------------------------
module wiper_host #(
   parameter POWERUP_CYC = `CYC_US(`POWERUP_WAIT_US),
   parameter STORAGE_CYC = `CYC_US(`STORAGE_US),
   parameter TW = 24
) (
   // Clock and reset.
   input wire core_clk,
   input wire rstn,
   // User command port.
   input wire cmd_valid,
   input wire cmd_up,
   input wire [4:0] cmd_steps,
   input wire cmd_store,
   input wire cmd_store_only,
   output reg cmd_ready,
   // Host view of the wiper position, zero from reset.
   output reg [4:0] pos_est,
   // Device pins.
   output reg sel_n,
   output reg step_n,
   output reg dir_up
);
   // ----------------------------------------
   // States and timing counts.
   // ----------------------------------------
   localparam S_PWR = 4'h0;
   localparam S_IDLE = 4'h1;
   localparam S_SEL = 4'h2;
   localparam S_DIR = 4'h3;
   localparam S_LOW = 4'h4;
   localparam S_HIGH = 4'h5;
   localparam S_END = 4'h6;
   localparam S_RISE = 4'h7;
   localparam S_DESEL = 4'h8;
   localparam S_PULSE = 4'h9;
   localparam S_WRITE = 4'hA;
   // Raw counts are integers; they are cut to the timer width on purpose below.
   localparam integer N_CSI = `CYC_NS(`CS_TO_INC_NS);
   localparam integer N_DIR = `CYC_NS(`DIR_SETUP_NS);
   localparam integer N_LOW = `CYC_NS(`INC_LOW_NS);
   localparam integer N_HIGH = `CYC_NS(`INC_HIGH_NS);
   localparam integer N_IC = `CYC_NS(`STROBE_TO_DESELECT_NS);
   localparam integer N_DES = `CYC_NS(`DESELECT_NS);
   localparam integer N_CLP = `CYC_NS(`SELECT_PULSE_NS);
   localparam integer N_PU = POWERUP_CYC;
   localparam integer N_WST = STORAGE_CYC;
   localparam [TW-1:0] C_CSI = N_CSI[TW-1:0];
   localparam [TW-1:0] C_DIR = N_DIR[TW-1:0];
   localparam [TW-1:0] C_LOW = N_LOW[TW-1:0];
   localparam [TW-1:0] C_HIGH = N_HIGH[TW-1:0];
   localparam [TW-1:0] C_IC = N_IC[TW-1:0];
   localparam [TW-1:0] C_DES = N_DES[TW-1:0];
   localparam [TW-1:0] C_CLP = N_CLP[TW-1:0];
   localparam [TW-1:0] C_PU = N_PU[TW-1:0];
   localparam [TW-1:0] C_WST = N_WST[TW-1:0];
   reg [3:0] state; // Current sequencer state.
   reg [4:0] steps_left; // Strobe edges still to issue.
   reg store_req; // Session ends with a store.
   reg t_load; // Restart the wait timer.
   reg [TW-1:0] t_count; // Value for the wait timer.
   wire t_done; // Wait has elapsed.
   // ----------------------------------------
   // Shared wait timer; at most one wait runs at a time.
   // ----------------------------------------
   hold_timer #(.W(TW)) u_timer (
      .core_clk(core_clk),
      .rstn(rstn),
      .load(t_load),
      .count(t_count),
      .done(t_done)
   );
   // ----------------------------------------
   // Sequencer.
   // ----------------------------------------
   // One process drives the pins so each comes from a flop. The timer is
   // loaded from the same process, one cycle ahead of its check.
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= S_PWR;
         sel_n <= 1'b1;
         step_n <= 1'b1;
         dir_up <= 1'b0;
         cmd_ready <= 1'b0;
         pos_est <= 5'h00;
         steps_left <= 5'h00;
         store_req <= 1'b0;
         t_load <= 1'b1;
         t_count <= C_PU;
      end else begin
         t_load <= 1'b0;
         case (state)
            // Hold pins idle until the device pins come alive.
            S_PWR: begin
               if (!t_load && t_done) begin
                  state <= S_IDLE;
                  cmd_ready <= 1'b1;
               end
            end
            // Accept a command; select stays high meanwhile.
            S_IDLE: begin
               if (cmd_valid) begin
                  cmd_ready <= 1'b0;
                  store_req <= cmd_store;
                  steps_left <= cmd_steps;
                  dir_up <= cmd_up;
                  sel_n <= 1'b0;
                  t_load <= 1'b1;
                  if (cmd_store_only) begin
                     t_count <= C_CLP;
                     state <= S_PULSE;
                  end else begin
                     t_count <= C_CSI;
                     state <= S_SEL;
                  end
               end
            end
            // Select to strobe setup, then direction setup.
            S_SEL: begin
               if (!t_load && t_done) begin
                  t_load <= 1'b1;
                  t_count <= C_DIR;
                  state <= S_DIR;
               end
            end
            S_DIR: begin
               if (!t_load && t_done) begin
                  if (steps_left == 5'h00) begin
                     // No steps: select rises with strobe high, which the device
                     // takes as a store, so the write wait must be kept.
                     store_req <= 1'b1;
                     state <= S_END;
                  end else begin
                     step_n <= 1'b0;
                     steps_left <= steps_left - 5'h01;
                     // Track the device's saturating position.
                     if (dir_up && pos_est != `POS_MAX) begin
                        pos_est <= pos_est + 5'h01;
                     end else if (!dir_up && pos_est != 5'h00) begin
                        pos_est <= pos_est - 5'h01;
                     end
                     t_load <= 1'b1;
                     t_count <= C_LOW;
                     state <= S_LOW;
                  end
               end
            end
            // Strobe low time; the last edge keeps strobe low.
            S_LOW: begin
               if (!t_load && t_done) begin
                  if (steps_left == 5'h00) begin
                     state <= S_END;
                  end else begin
                     step_n <= 1'b1;
                     t_load <= 1'b1;
                     t_count <= C_HIGH;
                     state <= S_HIGH;
                  end
               end
            end
            S_HIGH: begin
               if (!t_load && t_done) begin
                  t_load <= 1'b1;
                  t_count <= C_DIR;
                  state <= S_DIR;
               end
            end
            // Choose how the session closes.
            S_END: begin
               if (store_req) begin
                  step_n <= 1'b1;
                  t_load <= 1'b1;
                  t_count <= C_IC;
                  state <= S_RISE;
               end else begin
                  // Select rises while strobe is still low.
                  sel_n <= 1'b1;
                  t_load <= 1'b1;
                  t_count <= C_DES;
                  state <= S_DESEL;
               end
            end
            // Strobe high for the deselect lead time, then release select.
            S_RISE: begin
               if (!t_load && t_done) begin
                  sel_n <= 1'b1;
                  t_load <= 1'b1;
                  t_count <= C_WST;
                  state <= S_WRITE;
               end
            end
            // Release strobe only after select is already high.
            S_DESEL: begin
               step_n <= 1'b1;
               if (!t_load && t_done) begin
                  cmd_ready <= 1'b1;
                  state <= S_IDLE;
               end
            end
            // Select low pulse with strobe high.
            S_PULSE: begin
               if (!t_load && t_done) begin
                  sel_n <= 1'b1;
                  t_load <= 1'b1;
                  t_count <= C_WST;
                  state <= S_WRITE;
               end
            end
            // The device ignores pins while it writes; stay quiet.
            S_WRITE: begin
               if (!t_load && t_done) begin
                  cmd_ready <= 1'b1;
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
               sel_n <= 1'b1;
               step_n <= 1'b1;
               cmd_ready <= 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* wiper_host_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Pin order checks on the host.
// ------------------------------
module wiper_host_checker (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Command port and device pins.
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic sel_n,
   input wire logic step_n,
   input wire logic dir_up
);
   logic [7:0] hi_cnt; // Cycles the strobe has stood high.
   // Counts strobe-high cycles inside a session only. A strobe that rose while
   // deselected says nothing about the store lead time, so it reads as full.
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) hi_cnt <= 8'hFF;
      else if (sel_n) hi_cnt <= 8'hFF;
      else if (!step_n) hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   idle_pins_a: assert property (cmd_ready |-> sel_n && step_n) else $error("busy pins");
   take_cmd_a: assert property (cmd_valid && cmd_ready |=> !sel_n && !cmd_ready)
      else $error("not taken");
   sel_setup_a: assert property ($fell(sel_n) |-> step_n [*5]) else $error("early step");
   step_sel_a: assert property ($fell(step_n) |-> !sel_n) else $error("step unselected");
   dir_setup_a: assert property ($changed(dir_up) && step_n |-> step_n [*8] ##1 step_n [*2])
      else $error("dir setup");
   low_hold_a: assert property ($fell(step_n) |-> !step_n [*5]) else $error("low short");
   pulse_len_a: assert property ($fell(sel_n) |-> !sel_n [*8] ##1 !sel_n [*2])
      else $error("pulse short");
   store_gap_a: assert property ($rose(sel_n) |-> !step_n || hi_cnt >= 8'h32)
      else $error("deselect early");
endmodule
bind wiper_host wiper_host_checker i_chk (.core_clk(core_clk), .rstn(rstn),
   .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .sel_n(sel_n), .step_n(step_n),
   .dir_up(dir_up));
`default_nettype wire

/* wiper_dev.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Behavioural device: wiper, store and write time.
// ------------------------------
module wiper_dev #(
   parameter PU_NS = 200,
   parameter WR_NS = 250
) (
   // Pins from the host.
   input wire logic sel_n,
   input wire logic step_n,
   input wire logic dir_up,
   // Wiper and stored setting.
   output logic [4:0] pos,
   output logic [4:0] nv
);
   logic busy = 1'b0; // High while a store runs.
   // Power-up loads the stored setting, so unstored moves are gone.
   initial begin
      nv = 5'h00;
      pos = nv;
   end
   // Steps count only when selected, awake and not storing; ends clamp.
   always @(negedge step_n) begin
      if (!sel_n && !busy && $time >= PU_NS) begin
         if (dir_up && pos != 5'h1F) pos = pos + 5'h01;
         else if (!dir_up && pos != 5'h00) pos = pos - 5'h01;
      end
   end
   // Deselect with strobe high stores; with strobe low nothing is kept.
   always @(posedge sel_n) begin
      if (step_n && !busy && $time >= PU_NS) begin
         nv = pos;
         busy = 1'b1;
         #(WR_NS) busy = 1'b0;
      end
   end
endmodule
`default_nettype wire

/* tb_wiper_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Bench: host driving a behavioural device.
// ------------------------------
module tb_wiper_host;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_up = 1'b0, cmd_store = 1'b0, cmd_store_only = 1'b0;
   logic [4:0] cmd_steps = 5'h00;
   logic cmd_ready, sel_n, step_n, dir_up;
   logic [4:0] pos_est, dev_pos, dev_nv;
   integer err_count = 0, compares = 0, exp_pos = 0, exp_nv = 0, k, i;
   // Up, steps, store, store only: moves, clamps, stores and drops.
   logic [7:0] cases [0:5] = '{8'h94, 8'hFE, 8'h0C, 8'h01, 8'h7C, 8'h00};
   // Short waits keep the run small; they still match the device's wake-up time and exceed its write time.
   wiper_host #(.POWERUP_CYC(20), .STORAGE_CYC(30)) i_dut (.core_clk(core_clk),
      .rstn(rstn), .cmd_valid(cmd_valid), .cmd_up(cmd_up), .cmd_steps(cmd_steps),
      .cmd_store(cmd_store), .cmd_store_only(cmd_store_only), .cmd_ready(cmd_ready),
      .pos_est(pos_est), .sel_n(sel_n), .step_n(step_n), .dir_up(dir_up));
   wiper_dev i_dev (.sel_n(sel_n), .step_n(step_n), .dir_up(dir_up), .pos(dev_pos),
      .nv(dev_nv));
   // Free-running 100 MHz clock.
   initial forever #5 core_clk = ~core_clk;
   // Prints the counts and the verdict, then stops.
   task finish_test;
      begin
         $display("err_count %0d compares %0d", err_count, compares);
         if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Compares a wiper value with the bench's own account.
   task chk(input logic [4:0] got, input logic [4:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Bounded wait for an idle host; a hang counts and ends the run.
   task wait_ready;
      begin
         k = 0;
         while (cmd_ready !== 1'b1) begin
            @(posedge core_clk);
            #1;
            k = k + 1;
            if (k > 2000) begin
               err_count = err_count + 1;
               finish_test;
            end
         end
      end
   endtask
   // One command, held until taken, then checked once the host is idle.
   task run(input logic [7:0] c);
      begin
         wait_ready;
         {cmd_up, cmd_steps, cmd_store, cmd_store_only} = c;
         cmd_valid = 1'b1;
         @(posedge core_clk);
         #1;
         cmd_valid = 1'b0;
         if (c[0]) exp_nv = exp_pos;
         else begin
            exp_pos = c[7] ? exp_pos + c[6:2] : exp_pos - c[6:2];
            exp_pos = exp_pos > 31 ? 31 : (exp_pos < 0 ? 0 : exp_pos);
            // A session without steps ends as a select pulse, which stores.
            if (c[1] || c[6:2] == 5'h00) exp_nv = exp_pos;
         end
         wait_ready;
         chk(pos_est, exp_pos[4:0]);
         chk(dev_pos, exp_pos[4:0]);
         chk(dev_nv, exp_nv[4:0]);
      end
   endtask
   // Reset, then the table, then random commands.
   initial begin
      k = $urandom(59);
      repeat (5) @(posedge core_clk);
      #1;
      rstn = 1'b1;
      wait_ready;
      chk(pos_est, 5'h00);
      for (i = 0; i < 6; i = i + 1) run(cases[i]);
      for (i = 0; i < 12; i = i + 1) run(8'($urandom));
      finish_test;
   end
endmodule
`default_nettype wire
